// ### addr_gen_pkg.sv
// Shared constants, modes and states for the operand address generator
// Functional notes
// - Immediate byte after opcode is the operand.
// - Immediate extended: two bytes form 16-bit operand.
// - Extended: two bytes form full 16-bit address.
// - Low-order byte read first, high-order next.
// - Restart loads counter with one of eight page-zero addresses.
// - Relative target is next opcode plus signed displacement.
// - Relative jump is opcode plus one displacement byte.
// - Indexed: selected index plus signed displacement, index kept.
// - Register mode decodes register from opcode fields.
// - Implied arithmetic always writes the accumulator.
// - Indirect 16-bit: pointer low byte, pointer+1 high.
// - Bit ops: three-bit field picks one of eight.
// - Push and pop always move a whole pair.
// - Push writes upper byte at pointer minus one.
// - Push writes lower at minus two, pointer drops two.
// - Pop loads low register from pointer address.
// - Pop loads high register from pointer plus one.
// - After both pop reads, pointer rises by two.
`default_nettype none
package addr_gen_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_BITS = 16;
    localparam int MODE_W = 4;
    localparam logic [15:0] NEXT_BYTE = 16'h0001;
    localparam logic [15:0] PAIR_STEP = 16'h0002;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] RESET_SP = 16'h0000;
    localparam logic [7:0] STEP_DISP = 8'h01;
    localparam logic [7:0] BIT_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] ACC_CODE = 3'h7;
    localparam int SRC_LO = 0;
    localparam int SRC_HI = 2;
    localparam int DST_LO = 3;
    localparam int DST_HI = 5;
    localparam int BIT_LO = 3;
    localparam int BIT_HI = 5;
    localparam int RST_LO = 3;
    localparam int RST_HI = 5;
    localparam int INDEX_SEL_BIT = 5;

    typedef enum logic [3:0] {
        M_IMM = 4'h0,
        M_IMM_EXT = 4'h1,
        M_EXT = 4'h2,
        M_RESTART = 4'h3,
        M_REL = 4'h4,
        M_INDEXED = 4'h5,
        M_REGISTER = 4'h6,
        M_IMPLIED = 4'h7,
        M_INDIRECT = 4'h8,
        M_PUSH = 4'h9,
        M_POP = 4'hA
    } mode_type;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_READ_LO = 3'h1,
        S_READ_HI = 3'h2,
        S_WRITE_HI = 3'h3,
        S_WRITE_LO = 3'h4
    } state_type;
endpackage
`default_nettype wire

// ### offset_adder.sv
// Base plus sign-extended displacement adder
`timescale 1ns/1ps
`default_nettype none
module offset_adder
#(
    parameter int BASE_W = 16,
    parameter int DISP_W = 8
)
(
    input wire logic [BASE_W-1:0] base,
    input wire logic [DISP_W-1:0] disp,
    output logic [BASE_W-1:0] sum
);
    if (DISP_W < 1 || DISP_W > BASE_W)
    begin : g_bad_width
        $error("offset_adder: displacement wider than base");
    end

    always_comb
    begin
        sum = base + {{(BASE_W-DISP_W){disp[DISP_W-1]}}, disp};
    end
endmodule
`default_nettype wire

// ### operand_address_generator.sv
// Operand and effective-address sequencer with stack push and pop
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator
    import addr_gen_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [MODE_W-1:0] mode_in,
    input wire logic [BYTE_W-1:0] opcode_in,
    input wire logic jump_in,
    input wire logic wide_in,
    input wire logic bit_op_in,
    input wire logic [ADDR_BITS-1:0] first_index_base,
    input wire logic [ADDR_BITS-1:0] second_index_base,
    input wire logic [ADDR_BITS-1:0] memory_pointer_pair,
    input wire logic [ADDR_BITS-1:0] push_pair,
    input wire logic pc_load,
    input wire logic [ADDR_BITS-1:0] pc_value,
    input wire logic sp_load,
    input wire logic [ADDR_BITS-1:0] sp_value,
    input wire logic mem_ack,
    input wire logic [BYTE_W-1:0] mem_rdata,
    output logic [ADDR_BITS-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [BYTE_W-1:0] mem_wdata,
    output logic [ADDR_BITS-1:0] program_counter,
    output logic [ADDR_BITS-1:0] stack_pointer,
    output logic [ADDR_BITS-1:0] operand_value,
    output logic [ADDR_BITS-1:0] effective_address,
    output logic [2:0] reg_src_sel,
    output logic [2:0] reg_dst_sel,
    output logic [BYTE_W-1:0] bit_mask,
    output logic busy,
    output logic done
);
    state_type state;
    state_type first_state;
    mode_type mode;
    mode_type mode_req;
    logic jump;
    logic [BYTE_W-1:0] lo_byte;
    logic [ADDR_BITS-1:0] disp_base;
    logic [ADDR_BITS-1:0] disp_sum;
    logic [ADDR_BITS-1:0] next_addr;
    logic [ADDR_BITS-1:0] restart_target;
    logic start_take;
    logic lo_done;
    logic hi_done;
    logic whi_done;
    logic wlo_done;
    logic lo_last;
    logic pc_based;

    assign mode_req = mode_type'(mode_in);
    assign start_take = start && (state == S_IDLE);
    assign lo_done = (state == S_READ_LO) && mem_ack;
    assign hi_done = (state == S_READ_HI) && mem_ack;
    assign whi_done = (state == S_WRITE_HI) && mem_ack;
    assign wlo_done = (state == S_WRITE_LO) && mem_ack;
    // Single-byte fetches finish after the low read
    assign lo_last = (mode == M_IMM) || (mode == M_REL) || (mode == M_INDEXED);
    assign pc_based = (mode_req == M_IMM) || (mode_req == M_IMM_EXT) || (mode_req == M_EXT)
        || (mode_req == M_REL) || (mode_req == M_INDEXED);
    assign restart_target = ADDR_BITS'(opcode_in[RST_HI:RST_LO]) << RST_LO;

    always_comb
    begin
        case (mode_req)
            M_IMM, M_IMM_EXT, M_EXT, M_REL, M_INDEXED, M_POP:
                first_state = S_READ_LO;
            M_INDIRECT:
                first_state = wide_in ? S_READ_LO : S_IDLE;
            M_PUSH:
                first_state = S_WRITE_HI;
            default:
                first_state = S_IDLE;
        endcase
    end

    // Index base picked by opcode; the index registers are only read
    always_comb
    begin
        if (mode != M_INDEXED)
            disp_base = program_counter;
        else if (opcode_in[INDEX_SEL_BIT])
            disp_base = second_index_base;
        else
            disp_base = first_index_base;
    end

    offset_adder #(.BASE_W(ADDR_BITS), .DISP_W(BYTE_W)) disp_add (
        .base(disp_base),
        .disp(mem_rdata),
        .sum(disp_sum)
    );

    offset_adder #(.BASE_W(ADDR_BITS), .DISP_W(BYTE_W)) step_add (
        .base(mem_addr),
        .disp(STEP_DISP),
        .sum(next_addr)
    );

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= S_IDLE;
        else
        begin
            case (state)
                S_IDLE:
                    if (start)
                        state <= first_state;
                S_READ_LO:
                    if (mem_ack)
                        state <= lo_last ? S_IDLE : S_READ_HI;
                S_READ_HI:
                    if (mem_ack)
                        state <= S_IDLE;
                S_WRITE_HI:
                    if (mem_ack)
                        state <= S_WRITE_LO;
                S_WRITE_LO:
                    if (mem_ack)
                        state <= S_IDLE;
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode <= M_IMM;
            jump <= 1'b0;
            lo_byte <= BYTE_ZERO;
        end
        else if (start_take)
        begin
            mode <= mode_req;
            jump <= jump_in;
            lo_byte <= push_pair[BYTE_W-1:0];
        end
        else if (lo_done)
            lo_byte <= mem_rdata;
    end

    // Memory port; low byte always goes first on reads
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_addr <= RESET_PC;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= BYTE_ZERO;
        end
        else if (start_take && first_state == S_READ_LO)
        begin
            mem_rd <= 1'b1;
            if (mode_req == M_POP)
                mem_addr <= stack_pointer;
            else if (mode_req == M_INDIRECT)
                mem_addr <= memory_pointer_pair;
            else
                mem_addr <= program_counter;
        end
        else if (start_take && first_state == S_WRITE_HI)
        begin
            mem_wr <= 1'b1;
            mem_addr <= stack_pointer - NEXT_BYTE;
            mem_wdata <= push_pair[ADDR_BITS-1:BYTE_W];
        end
        else if (lo_done)
        begin
            mem_rd <= !lo_last;
            mem_addr <= next_addr;
        end
        else if (hi_done)
            mem_rd <= 1'b0;
        else if (whi_done)
        begin
            mem_addr <= stack_pointer - PAIR_STEP;
            mem_wdata <= lo_byte;
        end
        else if (wlo_done)
            mem_wr <= 1'b0;
    end

    // Loads are taken only while idle so an operation never sees them
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            program_counter <= RESET_PC;
        else if (start_take && pc_based)
            program_counter <= program_counter + NEXT_BYTE;
        else if (start_take && mode_req == M_RESTART)
            program_counter <= restart_target;
        else if (pc_load && state == S_IDLE && !start)
            program_counter <= pc_value;
        else if (lo_done && (mode == M_IMM_EXT || mode == M_EXT))
            program_counter <= program_counter + NEXT_BYTE;
        else if (lo_done && mode == M_REL)
            program_counter <= disp_sum;
        else if (hi_done && mode == M_EXT && jump)
            program_counter <= {mem_rdata, lo_byte};
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            stack_pointer <= RESET_SP;
        else if (sp_load && state == S_IDLE && !start)
            stack_pointer <= sp_value;
        else if (wlo_done)
            stack_pointer <= stack_pointer - PAIR_STEP;
        else if (hi_done && mode == M_POP)
            stack_pointer <= stack_pointer + PAIR_STEP;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_src_sel <= 3'h0;
            reg_dst_sel <= 3'h0;
            bit_mask <= BYTE_ZERO;
            effective_address <= RESET_PC;
        end
        else if (start_take)
        begin
            reg_src_sel <= opcode_in[SRC_HI:SRC_LO];
            if (mode_req == M_IMPLIED)
                reg_dst_sel <= ACC_CODE;
            else
                reg_dst_sel <= opcode_in[DST_HI:DST_LO];
            if (bit_op_in)
                bit_mask <= BIT_ONE << opcode_in[BIT_HI:BIT_LO];
            else
                bit_mask <= BYTE_ZERO;
            if (mode_req == M_INDIRECT)
                effective_address <= memory_pointer_pair;
            else if (mode_req == M_RESTART)
                effective_address <= restart_target;
        end
        else if (lo_done && (mode == M_REL || mode == M_INDEXED))
            effective_address <= disp_sum;
        else if (hi_done && mode == M_EXT)
            effective_address <= {mem_rdata, lo_byte};
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            operand_value <= RESET_PC;
        else if (lo_done && mode == M_IMM)
            operand_value <= {BYTE_ZERO, mem_rdata};
        else if (hi_done && mode != M_EXT)
            operand_value <= {mem_rdata, lo_byte};
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            done <= (start_take && first_state == S_IDLE) || (lo_done && lo_last)
                || hi_done || wlo_done;
            if (start_take)
                busy <= (first_state != S_IDLE);
            else if ((lo_done && lo_last) || hi_done || wlo_done)
                busy <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence push_upper_s;
        mem_wr && !mem_rd && mem_addr == stack_pointer - NEXT_BYTE;
    endsequence

    sequence push_lower_s;
        mem_wr && mem_addr == stack_pointer - PAIR_STEP;
    endsequence

    a_imm_byte: assert property (lo_done && mode == M_IMM |=>
        done && operand_value == {BYTE_ZERO, $past(mem_rdata)})
        else $error("immediate operand not the fetched byte");
    a_ext_pair: assert property (hi_done && mode == M_IMM_EXT |=>
        operand_value == {$past(mem_rdata), $past(lo_byte)})
        else $error("extended immediate operand wrong");
    a_ext_jump: assert property (hi_done && mode == M_EXT && jump |=>
        program_counter == {$past(mem_rdata), $past(lo_byte)})
        else $error("extended jump target not loaded");
    a_byte_order: assert property (lo_done && !lo_last |=>
        mem_rd && mem_addr == $past(mem_addr) + NEXT_BYTE)
        else $error("high byte not read at next address");
    a_restart_page: assert property (start_take && mode_req == M_RESTART |=>
        program_counter == ADDR_BITS'($past(opcode_in[RST_HI:RST_LO])) << RST_LO && done)
        else $error("restart target wrong");
    a_rel_target: assert property (lo_done && mode == M_REL |=>
        program_counter == $past(program_counter)
            + {{BYTE_W{$past(mem_rdata[BYTE_W-1])}}, $past(mem_rdata)})
        else $error("relative target wrong");
    a_rel_length: assert property (lo_done && mode == M_REL |=>
        done && !mem_rd && !busy) else $error("relative jump read more than one byte");
    a_implied_acc: assert property (start_take && mode_req == M_IMPLIED |=>
        reg_dst_sel == ACC_CODE && done) else $error("implied destination not accumulator");
    a_bit_select: assert property (start_take && bit_op_in |=> $onehot(bit_mask))
        else $error("bit mask not one-hot");
    a_push_upper: assert property (start_take && mode_req == M_PUSH |=> push_upper_s)
        else $error("push upper byte address wrong");
    a_push_lower: assert property (whi_done |=> push_lower_s)
        else $error("push lower byte address wrong");
    a_push_drop: assert property (wlo_done |=>
        stack_pointer == $past(stack_pointer) - PAIR_STEP && done)
        else $error("push pointer not lowered by two");
    a_pop_low: assert property (start_take && mode_req == M_POP |=>
        mem_rd && mem_addr == stack_pointer) else $error("pop low read address wrong");
    a_pop_high: assert property (lo_done && mode == M_POP |=>
        mem_rd && mem_addr == stack_pointer + NEXT_BYTE)
        else $error("pop high read address wrong");
    a_pop_rise: assert property (hi_done && mode == M_POP |=>
        stack_pointer == $past(stack_pointer) + PAIR_STEP)
        else $error("pop pointer not raised by two");
endmodule
`default_nettype wire

// ### byte_memory_model.sv
// Byte-wide code, data and stack memory facing the address generator
`timescale 1ns/1ps
`default_nettype none
module byte_memory_model
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [1:0] wait_cycles,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] waited;
    logic [7:0] last;

    assign mem_ack = (mem_rd || mem_wr) && (waited >= wait_cycles);
    // Bus not answering shows the inverse of the last byte, so stale data never matches
    assign mem_rdata = (mem_rd && mem_ack) ? mem[mem_addr] : ~last;

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waited <= 2'h0;
            last <= 8'h00;
        end
        else if (mem_ack)
        begin
            waited <= 2'h0;
            last <= mem_rd ? mem_rdata : mem_wdata;
        end
        else if (mem_rd || mem_wr)
        begin
            waited <= waited + 2'h1;
        end
    end

    // Plain always so the bench may preload the array
    always @(posedge ref_clk)
    begin
        if (mem_wr && mem_ack)
        begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

// ### test_operand_address_generator.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module test_operand_address_generator;
    import addr_gen_pkg::*;
    logic ref_clk, rst_b, start, jump_in, wide_in, bit_op_in, pc_load, sp_load, mem_ack;
    logic [3:0] mode_in;
    logic [7:0] opcode_in, mem_rdata, mem_wdata, bit_mask;
    logic [15:0] first_index_base, second_index_base, memory_pointer_pair, push_pair;
    logic [15:0] pc_value, sp_value, mem_addr, program_counter, stack_pointer;
    logic [15:0] operand_value, effective_address;
    logic mem_rd, mem_wr, busy, done;
    logic [2:0] reg_src_sel, reg_dst_sel;
    logic [1:0] wait_cycles;
    int n_fail, comparisons, cycles, k;

    operand_address_generator operand_address_generator_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .start(start), .mode_in(mode_in), .opcode_in(opcode_in), .jump_in(jump_in),
        .wide_in(wide_in), .bit_op_in(bit_op_in), .first_index_base(first_index_base),
        .second_index_base(second_index_base), .memory_pointer_pair(memory_pointer_pair),
        .push_pair(push_pair), .pc_load(pc_load), .pc_value(pc_value), .sp_load(sp_load),
        .sp_value(sp_value), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .program_counter(program_counter), .stack_pointer(stack_pointer),
        .operand_value(operand_value), .effective_address(effective_address),
        .reg_src_sel(reg_src_sel), .reg_dst_sel(reg_dst_sel), .bit_mask(bit_mask),
        .busy(busy), .done(done));

    byte_memory_model byte_memory_model_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always #5 ref_clk = ~ref_clk;

    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Runs far beyond the few hundred cycles the scenarios need
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic load_regs(input logic [15:0] pc, input logic [15:0] sp);
        @(negedge ref_clk);
        pc_load = 1'b1;
        sp_load = 1'b1;
        pc_value = pc;
        sp_value = sp;
        @(negedge ref_clk);
        pc_load = 1'b0;
        sp_load = 1'b0;
    endtask

    task automatic go(input logic [3:0] mode, input logic [7:0] op, input logic [2:0] fl);
        int n;
        @(negedge ref_clk);
        mode_in = mode;
        opcode_in = op;
        {jump_in, wide_in, bit_op_in} = fl;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(n < 40), 16'h0001);
    endtask

    task automatic immediate_modes();
        byte_memory_model_i.mem[16'h1000] = 8'h5A;
        byte_memory_model_i.mem[16'h2000] = 8'h34;
        byte_memory_model_i.mem[16'h2001] = 8'h12;
        load_regs(16'h1000, 16'h0000);
        go(M_IMM, 8'h3E, 3'h0);
        check(operand_value, 16'h005A);
        check(program_counter, 16'h1001);
        wait_cycles = 2'h2;
        load_regs(16'h2000, 16'h0000);
        go(M_IMM_EXT, 8'h21, 3'h0);
        check(operand_value, 16'h1234);
        check(program_counter, 16'h2002);
        wait_cycles = 2'h0;
    endtask

    task automatic extended_jump();
        byte_memory_model_i.mem[16'h3000] = 8'hCD;
        byte_memory_model_i.mem[16'h3001] = 8'hAB;
        load_regs(16'h3000, 16'h0000);
        go(M_EXT, 8'hC3, 3'h4);
        check(program_counter, 16'hABCD);
        check(effective_address, 16'hABCD);
        byte_memory_model_i.mem[16'h3100] = 8'hEF;
        byte_memory_model_i.mem[16'h3101] = 8'hBE;
        load_regs(16'h3100, 16'h0000);
        go(M_EXT, 8'h3A, 3'h0);
        check(effective_address, 16'hBEEF);
        check(program_counter, 16'h3102);
    endtask

    task automatic restarts();
        for (k = 0; k < 8; k++)
        begin
            go(M_RESTART, 8'hC7 | 8'(k << 3), 3'h0);
            check(program_counter, 16'(k * 8));
        end
        go(M_RESTART, 8'hFF, 3'h0);
        check(program_counter, 16'h0038);
    endtask

    task automatic relative_jumps();
        byte_memory_model_i.mem[16'h4000] = 8'h80;
        byte_memory_model_i.mem[16'h4080] = 8'h7F;
        load_regs(16'h4000, 16'h0000);
        go(M_REL, 8'h18, 3'h0);
        check(program_counter, 16'h3F81);
        check(effective_address, 16'h3F81);
        load_regs(16'h4080, 16'h0000);
        go(M_REL, 8'h18, 3'h0);
        check(program_counter, 16'h4100);
    endtask

    task automatic indexed_and_registers();
        byte_memory_model_i.mem[16'h0100] = 8'hFE;
        byte_memory_model_i.mem[16'h0101] = 8'h10;
        load_regs(16'h0100, 16'h0000);
        go(M_INDEXED, 8'h46, 3'h0);
        check(effective_address, 16'h4FFE);
        go(M_INDEXED, 8'h66, 3'h0);
        check(effective_address, 16'h6010);
        go(M_REGISTER, 8'h41, 3'h0);
        check({13'h0, reg_src_sel}, 16'h0001);
        check({13'h0, reg_dst_sel}, 16'h0000);
        go(M_IMPLIED, 8'h80, 3'h0);
        check({13'h0, reg_dst_sel}, 16'h0007);
        for (k = 0; k < 8; k++)
        begin
            go(M_REGISTER, 8'h40 | 8'(k << 3), 3'h1);
            check({8'h00, bit_mask}, 16'(1 << k));
        end
    endtask

    task automatic indirect_wide();
        memory_pointer_pair = 16'h70FF;
        byte_memory_model_i.mem[16'h70FF] = 8'hEF;
        byte_memory_model_i.mem[16'h7100] = 8'hBE;
        go(M_INDIRECT, 8'h2A, 3'h2);
        check(operand_value, 16'hBEEF);
        memory_pointer_pair = 16'h1234;
        go(M_INDIRECT, 8'h7E, 3'h0);
        check(effective_address, 16'h1234);
        check(operand_value, 16'hBEEF);
    endtask

    task automatic push_then_pop();
        wait_cycles = 2'h1;
        load_regs(16'h0000, 16'h01FF);
        push_pair = 16'h7A40;
        go(M_PUSH, 8'hC5, 3'h0);
        check({8'h00, byte_memory_model_i.mem[16'h01FE]}, 16'h007A);
        check({8'h00, byte_memory_model_i.mem[16'h01FD]}, 16'h0040);
        check(stack_pointer, 16'h01FD);
        push_pair = 16'h0000;
        go(M_POP, 8'hE1, 3'h0);
        check(operand_value, 16'h7A40);
        check(stack_pointer, 16'h01FF);
        wait_cycles = 2'h0;
    endtask

    // Reset lands while a push waits on slow memory
    task automatic reset_midway();
        wait_cycles = 2'h3;
        load_regs(16'h1234, 16'h0300);
        @(negedge ref_clk);
        mode_in = M_PUSH;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        check({15'h0000, busy}, 16'h0001);
        check({15'h0000, mem_wr}, 16'h0001);
        rst_b = 1'b0;
        @(negedge ref_clk);
        rst_b = 1'b1;
        check({15'h0000, busy}, 16'h0000);
        check({15'h0000, mem_wr}, 16'h0000);
        check(stack_pointer, RESET_SP);
        check(program_counter, RESET_PC);
        wait_cycles = 2'h0;
        go(M_RESTART, 8'hEF, 3'h0);
        check(program_counter, 16'h0028);
    endtask

    initial
    begin
        {ref_clk, rst_b, start, jump_in, wide_in, bit_op_in, pc_load, sp_load} = 8'h00;
        {mode_in, opcode_in, wait_cycles} = 14'h0000;
        first_index_base = 16'h5000;
        second_index_base = 16'h6000;
        {memory_pointer_pair, push_pair, pc_value, sp_value} = 64'h0;
        {n_fail, comparisons, cycles} = 0;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        check(program_counter, RESET_PC);
        immediate_modes();
        extended_jump();
        restarts();
        relative_jumps();
        indexed_and_registers();
        indirect_wide();
        push_then_pop();
        reset_midway();
        finish_test();
    end
endmodule
`default_nettype wire
